// file: verilog/vrscp_pkg.sv
/*
 * Constants, field layout and types for the serial command port of the
 * voice record/playback block.
 * Assumes a 125 MHz core clock and a host acting as serial master.
 */
// Operation
// R1: A frame starts when slave select falls from high to low.
// R2: Host keeps select low through a frame and high between frames.
// R3: Input sampled on clock rise, output changed on clock fall, LSB first.
// R4: Frame is 11 address bits first, then cue, skip, power, direction, run.
// R5: Reaching end-of-message or array end raises the interrupt output.
// R6: Starting the next frame clears a pending interrupt.
// R7: Status shifts out while the next command shifts in.
// R8: Run bit set starts an operation; run bit clear ends it.
// R9: A received command acts only after select returns high.
// R10: Pattern 0 0 1 0 0 wakes the device; host waits the wake delay.
// R11: Pattern 0 0 1 1 1 starts playback at the given row.
// R12: Pattern 0 1 1 1 1 plays from the current row until message end or overflow.
// R13: Pattern 0 0 1 0 1 starts recording at the given row.
// R14: Pattern 0 1 1 0 1 records from the current row until overflow or stop.
// R15: Pattern 1 0 1 1 1 starts message skipping at the given row.
// R16: Pattern 1 1 1 1 1 skips to next message end, else overflow.
// R17: Pattern 0 1 1 X 0 halts the running operation.
// R18: Pattern X 1 0 X 0 halts and enters low-power standby.
// R19: Pattern 0 1 1 X 0 also reads overflow and end-of-message status.
// R20: Message skipping is accepted only when no operation is running.
// R21: Control bits are cue, skip address, power, direction, run.
// R22: The array has 600 rows of 1600 cells; the row field selects one.
// R23: Direction one plays, zero records; power one up, zero down.
// R24: Without skip bit the same row repeats at each row end; the code still advances rows in cue mode.
// R25: Status carries overflow, end-of-message and the ten-bit row pointer.
// R26: The data output is released while select is high.
package vrscp_pkg;
    localparam int CMD_BITS   = 16;
    localparam int ROW_BITS   = 10;
    localparam int STAT_BITS  = 12;
    localparam int CUE_POS    = 11;
    localparam int SKIP_POS   = 12;
    localparam int PWR_POS    = 13;
    localparam int DIR_POS    = 14;
    localparam int RUN_POS    = 15;

    localparam logic [ROW_BITS-1:0] LAST_ROW = 10'h257;
    localparam logic [ROW_BITS-1:0] ROW_RST  = 10'h000;
    localparam logic [4:0]          FRAME_LEN = 5'h10;
    localparam logic [2:0]          SYNC_RST = 3'h4;

    localparam int CLK_PERIOD_NS = 8;
    localparam int WAKE_DELAY_US = 25000;
    localparam int WAKE_CYCLES   = WAKE_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_CNT_BITS = 22;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PLAY,
        OP_REC,
        OP_CUE
    } vrscp_op_type;
endpackage

// file: verilog/vrscp_frame_if.sv
/*
 * Bundle between the command controller and the frame shifter.
 * Assumes both ends run on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface vrscp_frame_if;
    logic        frame_start;
    logic        ss_active;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        mosi_bit;
    logic [11:0] status_word;
    logic [15:0] cmd_word;
    logic [4:0]  bit_count;
    logic        miso_bit;
    logic        miso_en;

    modport ctrl (
        output frame_start, ss_active, sclk_rise, sclk_fall, mosi_bit, status_word,
        input  cmd_word, bit_count, miso_bit, miso_en
    );
    modport shift (
        input  frame_start, ss_active, sclk_rise, sclk_fall, mosi_bit, status_word,
        output cmd_word, bit_count, miso_bit, miso_en
    );
endinterface
`default_nettype wire

// file: verilog/vrscp_sync.sv
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk; only q may be read.
 */
`timescale 1ns/1ps
`default_nettype none
module vrscp_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d_async,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= RST_VAL;
            q       <= RST_VAL;
        end else begin
            meta_ff <= d_async;
            q       <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// file: verilog/vrscp_shifter.sv
/*
 * Frame shifter: collects command bits and sends status bits, LSB first.
 * Assumes edge strobes already synchronised to the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vrscp_shifter (
    input wire logic     clk,
    input wire logic     rst,
    vrscp_frame_if.shift fif
);
    import vrscp_pkg::*;

    logic [CMD_BITS-1:0]  cmd_ff;
    logic [STAT_BITS-1:0] out_ff;
    logic [4:0]           cnt_ff;
    logic                 miso_ff;
    logic                 oe_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_ff  <= '0;
            out_ff  <= '0;
            cnt_ff  <= 5'h00;
            miso_ff <= 1'b0;
            oe_ff   <= 1'b0;
        end else if (fif.frame_start) begin
            // First status bit must stand before the first rising edge
            cnt_ff  <= 5'h00;
            out_ff  <= {1'b0, fif.status_word[STAT_BITS-1:1]}; // see R7
            miso_ff <= fif.status_word[0];
            oe_ff   <= 1'b1;
        end else if (!fif.ss_active) begin
            oe_ff <= 1'b0; // see R26
        end else begin
            if (fif.sclk_rise) begin
                cmd_ff <= {fif.mosi_bit, cmd_ff[CMD_BITS-1:1]}; // see R3
                if (cnt_ff != FRAME_LEN) begin
                    cnt_ff <= cnt_ff + 5'h01;
                end
            end
            // A fall before any rise is the idle-high clock dropping, not a shift
            if (fif.sclk_fall && cnt_ff != 5'h00) begin
                miso_ff <= out_ff[0]; // see R3
                out_ff  <= {1'b0, out_ff[STAT_BITS-1:1]};
            end
        end
    end

    assign fif.cmd_word  = cmd_ff;
    assign fif.bit_count = cnt_ff;
    assign fif.miso_bit  = miso_ff;
    assign fif.miso_en   = oe_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_lsb_in;
        fif.sclk_rise && fif.ss_active && !fif.frame_start
            |=> cmd_ff[CMD_BITS-1] == $past(fif.mosi_bit);
    endproperty
    a_lsb_in: assert property (p_lsb_in) else $error("command bit not shifted in"); // see R3

    property p_release;
        !fif.ss_active |=> !oe_ff;
    endproperty
    a_release: assert property (p_release) else $error("data output not released"); // see R26

    property p_first_status;
        fif.frame_start |=> oe_ff && miso_ff == $past(fif.status_word[0]);
    endproperty
    a_first_status: assert property (p_first_status) else $error("status bit 0 not shown"); // see R7
endmodule
`default_nettype wire

// file: verilog/vrscp_port.sv
/*
 * Serial command port of the voice record/playback block: pin
 * synchronisation, frame edges, command decode, operation state,
 * row pointer, status flags, interrupt and wake timer.
 * Assumes the array engine pulses row_end at each row end and
 * eom_mark when a message end marker is met, on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vrscp_port #(
    parameter int WAKE_CYC = vrscp_pkg::WAKE_CYCLES
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          ss_n_pin,
    input  wire logic                          sclk_pin,
    input  wire logic                          mosi_pin,
    input  wire logic                          row_end,
    input  wire logic                          eom_mark,
    output logic                               miso_out,
    output logic                               miso_oe,
    output logic                               intr_n,
    output logic                               power_on,
    output logic                               wake_done,
    output vrscp_pkg::vrscp_op_type            op_state,
    output logic [vrscp_pkg::ROW_BITS-1:0]     row_ptr,
    output logic                               eom_flag,
    output logic                               ovf_flag
);
    import vrscp_pkg::*;

    vrscp_frame_if fif ();

    logic [2:0]               pin_sync;
    logic                     ss_n_s;
    logic                     sclk_s;
    logic                     mosi_s;
    logic                     ss_prev_ff;
    logic                     sclk_prev_ff;
    logic                     frame_end;
    logic                     cmd_go;

    logic                     c_cue;
    logic                     c_skip;
    logic                     c_pwr;
    logic                     c_dir;
    logic                     c_run;
    logic [ROW_BITS-1:0]      cmd_row;
    logic                     start_ok;

    vrscp_op_type             op_ff;
    logic [ROW_BITS-1:0]      row_ff;
    logic                     skip_ff;
    logic                     at_last;
    logic                     moves_row;
    logic                     row_advance;
    logic                     ev_eom;
    logic                     ev_ovf;

    logic                     power_ff;
    logic                     ready_ff;
    logic [WAKE_CNT_BITS-1:0] wake_cnt_ff;

    logic                     eom_ff;
    logic                     ovf_ff;
    logic                     intr_n_ff;

    vrscp_sync #(
        .WIDTH   (3),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk     (core_clk),
        .rst     (rst),
        .d_async ({ss_n_pin, sclk_pin, mosi_pin}),
        .q       (pin_sync)
    );

    vrscp_shifter u_shift (
        .clk (core_clk),
        .rst (rst),
        .fif (fif)
    );

    assign ss_n_s = pin_sync[2];
    assign sclk_s = pin_sync[1];
    assign mosi_s = pin_sync[0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ss_prev_ff   <= 1'b1;
            sclk_prev_ff <= 1'b0;
        end else begin
            ss_prev_ff   <= ss_n_s;
            sclk_prev_ff <= sclk_s;
        end
    end

    assign fif.frame_start = ss_prev_ff && !ss_n_s; // see R1
    assign fif.ss_active   = !ss_n_s;               // see R2
    assign fif.sclk_rise   = !ss_n_s && !sclk_prev_ff && sclk_s;
    assign fif.sclk_fall   = !ss_n_s && sclk_prev_ff && !sclk_s;
    assign fif.mosi_bit    = mosi_s;
    assign fif.status_word = {row_ff, eom_ff, ovf_ff}; // see R19, R25

    // Short frames are dropped; long ones keep their last sixteen bits
    assign frame_end = !ss_prev_ff && ss_n_s;
    assign cmd_go    = frame_end && (fif.bit_count == FRAME_LEN); // see R9

    assign cmd_row = fif.cmd_word[ROW_BITS-1:0]; // see R4, R22
    assign c_cue   = fif.cmd_word[CUE_POS];      // see R21
    assign c_skip  = fif.cmd_word[SKIP_POS];
    assign c_pwr   = fif.cmd_word[PWR_POS];
    assign c_dir   = fif.cmd_word[DIR_POS];
    assign c_run   = fif.cmd_word[RUN_POS];

    // Skipping needs the play direction and an idle engine
    assign start_ok = power_ff && !(c_cue && (!c_dir || op_ff != OP_IDLE)); // see R20

    assign at_last     = row_ff >= LAST_ROW;
    assign moves_row   = skip_ff || op_ff == OP_CUE; // see R24
    assign row_advance = op_ff != OP_IDLE && row_end && moves_row && !at_last;

    // Recording never stops on a marker; of these two events only the array end ends it
    assign ev_eom = !cmd_go && eom_mark
                    && (op_ff == OP_PLAY || op_ff == OP_CUE); // see R12, R16
    assign ev_ovf = !cmd_go && op_ff != OP_IDLE
                    && row_end && moves_row && at_last; // see R14, R16

    always_ff @(posedge core_clk) begin
        if (rst) begin
            op_ff   <= OP_IDLE;
            row_ff  <= ROW_RST;
            skip_ff <= 1'b0;
        end else if (cmd_go) begin
            if (!c_run || !c_pwr) begin
                op_ff <= OP_IDLE; // see R8, R17, R18
            end else if (start_ok) begin
                if (c_cue) begin
                    op_ff <= OP_CUE; // see R15, R16
                end else if (c_dir) begin
                    op_ff <= OP_PLAY; // see R11, R12, R23
                end else begin
                    op_ff <= OP_REC; // see R13, R14, R23
                end
                skip_ff <= c_skip;
                if (!c_skip) begin
                    row_ff <= cmd_row;
                end
            end
        end else if (ev_eom) begin
            op_ff <= OP_IDLE;
            // After a skip the pointer rests on the start of the next message
            if (op_ff == OP_CUE && !at_last) begin
                row_ff <= row_ff + 10'h001;
            end
        end else if (ev_ovf) begin
            op_ff <= OP_IDLE;
        end else if (row_advance) begin
            row_ff <= row_ff + 10'h001;
        end
    end

    // Status flags: an event in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            eom_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            if (ev_eom) begin
                eom_ff <= 1'b1;
            end else if (fif.frame_start) begin
                eom_ff <= 1'b0;
            end
            if (ev_ovf) begin
                ovf_ff <= 1'b1;
            end else if (fif.frame_start) begin
                ovf_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            intr_n_ff <= 1'b1;
        end else if (ev_eom || ev_ovf) begin
            intr_n_ff <= 1'b0; // see R5
        end else if (fif.frame_start) begin
            intr_n_ff <= 1'b1; // see R6
        end
    end

    // Wake timer runs only from a powered-down state; repeated wake
    // commands while up do not restart it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            power_ff    <= 1'b0;
            ready_ff    <= 1'b0;
            wake_cnt_ff <= '0;
        end else if (cmd_go && !c_pwr) begin
            power_ff    <= 1'b0; // see R18, R23
            ready_ff    <= 1'b0;
            wake_cnt_ff <= '0;
        end else if (cmd_go && !power_ff) begin
            power_ff    <= 1'b1; // see R10
            ready_ff    <= 1'b0;
            wake_cnt_ff <= WAKE_CNT_BITS'(WAKE_CYC);
        end else if (wake_cnt_ff != '0) begin
            wake_cnt_ff <= wake_cnt_ff - WAKE_CNT_BITS'(1);
            ready_ff    <= wake_cnt_ff == WAKE_CNT_BITS'(1);
        end
    end

    assign miso_out  = fif.miso_bit;
    assign miso_oe   = fif.miso_en;
    assign intr_n    = intr_n_ff;
    assign power_on  = power_ff;
    assign wake_done = ready_ff;
    assign op_state  = op_ff;
    assign row_ptr   = row_ff;
    assign eom_flag  = eom_ff;
    assign ovf_flag  = ovf_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_int_set;
        (ev_eom || ev_ovf) |=> !intr_n_ff ##1 (!intr_n_ff || $past(fif.frame_start));
    endproperty
    a_int_set: assert property (p_int_set) else $error("interrupt not raised"); // see R5

    property p_int_clear;
        fif.frame_start && !ev_eom && !ev_ovf |=> intr_n_ff && !eom_ff && !ovf_ff;
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt not cleared"); // see R6

    property p_hold_in_frame;
        !cmd_go && !ev_eom && !ev_ovf |=> $stable(op_ff);
    endproperty
    a_hold_in_frame: assert property (p_hold_in_frame) else $error("state moved without cause"); // see R9

    property p_stop;
        cmd_go && !c_run |=> op_ff == OP_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("stop command ignored"); // see R8

    property p_sleep;
        cmd_go && !c_pwr |=> op_ff == OP_IDLE && !power_ff && !ready_ff;
    endproperty
    a_sleep: assert property (p_sleep) else $error("standby not entered"); // see R18

    property p_set_play;
        cmd_go && power_ff && fif.cmd_word[15:11] == 5'h1c
            |=> op_ff == OP_PLAY && row_ff == $past(cmd_row);
    endproperty
    a_set_play: assert property (p_set_play) else $error("playback at row not started"); // see R11

    property p_set_rec;
        cmd_go && power_ff && fif.cmd_word[15:11] == 5'h14
            |=> op_ff == OP_REC && row_ff == $past(cmd_row);
    endproperty
    a_set_rec: assert property (p_set_rec) else $error("record at row not started"); // see R13

    property p_cue_refused;
        cmd_go && c_cue && c_run && c_pwr && op_ff != OP_IDLE |=> op_ff == $past(op_ff);
    endproperty
    a_cue_refused: assert property (p_cue_refused) else $error("skip taken while busy"); // see R20

    property p_ovf_stop;
        ev_ovf |=> ovf_ff && op_ff == OP_IDLE && row_ff == $past(row_ff);
    endproperty
    a_ovf_stop: assert property (p_ovf_stop) else $error("overflow not handled"); // see R22

    property p_wake;
        cmd_go && c_pwr && !power_ff && !c_run |=> (power_ff && !ready_ff) [*2];
    endproperty
    a_wake: assert property (p_wake) else $error("wake delay skipped"); // see R10

    property p_row_repeat;
        op_ff != OP_IDLE && row_end && !moves_row && !cmd_go && !ev_eom
            |=> row_ff == $past(row_ff);
    endproperty
    a_row_repeat: assert property (p_row_repeat) else $error("row not repeated"); // see R24

    property p_play_here;
        cmd_go && power_ff && fif.cmd_word[15:11] == 5'h1e
            |=> op_ff == OP_PLAY && row_ff == $past(row_ff);
    endproperty
    a_play_here: assert property (p_play_here) else $error("play from row not started"); // see R12

    property p_set_cue;
        cmd_go && power_ff && op_ff == OP_IDLE && fif.cmd_word[15:11] == 5'h1d
            |=> op_ff == OP_CUE && row_ff == $past(cmd_row);
    endproperty
    a_set_cue: assert property (p_set_cue) else $error("skip at row not started"); // see R15

    // An interrupt without a flag would leave the host nothing to read
    property p_int_flag;
        !intr_n_ff |-> eom_ff || ovf_ff;
    endproperty
    a_int_flag: assert property (p_int_flag) else $error("interrupt without status"); // see R5

    c_play_eom: cover property (op_ff == OP_PLAY && ev_eom);
    c_rec_ovf:  cover property (op_ff == OP_REC && ev_ovf);
    c_cue_eom:  cover property (op_ff == OP_CUE && ev_eom);
    c_status:   cover property (fif.frame_start && !intr_n_ff);
endmodule
`default_nettype wire

// file: dv/vrscp_host_model.sv
/*
 * Host model: serial master driving select, clock and data in frames.
 * Assumes the bench calls send_frame one edge-aligned step after a core edge.
 */
`timescale 1ns/1ps
`default_nettype none
module vrscp_host_model (
    output logic     ss_n,
    output logic     sclk,
    output logic     mosi,
    input wire logic miso_out,
    input wire logic miso_oe
);
    initial begin
        ss_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
    end

    // Clock stands still low between frames; half period 32 ns
    task automatic send_frame(input logic [15:0] cmd, input int nbits,
                              output logic [15:0] stat);
        stat = 16'h0000;
        ss_n = 1'b0;
        #64;
        for (int i = 0; i < nbits; i++) begin
            mosi = cmd[i];
            #32 sclk = 1'b1;
            // Sampled late in the high phase: the port's output lags its
            // falling edge by its synchroniser, so a rising-edge sample races
            #31 stat[i] = miso_oe ? miso_out : ~miso_out;
            #1 sclk = 1'b0;
        end
        #32 ss_n = 1'b1;
        mosi = ~mosi;
        #64;
    endtask
endmodule
`default_nettype wire

// file: dv/test_voice_recorder_serial_command_port.sv
/*
 * Testbench of the serial command port: row table of commands, then
 * event, status, refusal and wake cases.
 * Assumes the host model and the design port module.
 */
`timescale 1ns/1ps
`default_nettype none
module test_voice_recorder_serial_command_port;
    import vrscp_pkg::*;

    typedef struct {
        logic [15:0]  cmd;
        vrscp_op_type op;
        logic [9:0]   row;
        logic         pwr;
    } vrscp_row_type;

    logic         core_clk;
    logic         rst;
    logic         row_end;
    logic         eom_mark;
    wire          ss_n;
    wire          sclk;
    wire          mosi;
    logic         miso_out;
    logic         miso_oe;
    logic         intr_n;
    logic         power_on;
    logic         wake_done;
    vrscp_op_type op_state;
    logic [9:0]   row_ptr;
    logic         eom_flag;
    logic         ovf_flag;
    logic [15:0]  stat;
    int           bad_count;
    int           compares;

    vrscp_row_type rows [16] = '{
        '{16'h2000, OP_IDLE, 10'h000, 1'b1}, '{16'he005, OP_PLAY, 10'h005, 1'b1},
        '{16'h3000, OP_IDLE, 10'h005, 1'b1}, '{16'ha012, OP_REC,  10'h012, 1'b1},
        '{16'h7000, OP_IDLE, 10'h012, 1'b1}, '{16'hb155, OP_REC,  10'h012, 1'b1},
        '{16'h3000, OP_IDLE, 10'h012, 1'b1}, '{16'hf0aa, OP_PLAY, 10'h012, 1'b1},
        '{16'h3000, OP_IDLE, 10'h012, 1'b1}, '{16'he820, OP_CUE,  10'h020, 1'b1},
        '{16'h3000, OP_IDLE, 10'h020, 1'b1}, '{16'hf800, OP_CUE,  10'h020, 1'b1},
        '{16'h1000, OP_IDLE, 10'h020, 1'b0}, '{16'he005, OP_IDLE, 10'h020, 1'b1},
        '{16'h5800, OP_IDLE, 10'h020, 1'b0}, '{16'h2000, OP_IDLE, 10'h020, 1'b1}
    };

    vrscp_port #(.WAKE_CYC(20)) vrscp_port_inst (
        .core_clk  (core_clk),
        .rst       (rst),
        .ss_n_pin  (ss_n),
        .sclk_pin  (sclk),
        .mosi_pin  (mosi),
        .row_end   (row_end),
        .eom_mark  (eom_mark),
        .miso_out  (miso_out),
        .miso_oe   (miso_oe),
        .intr_n    (intr_n),
        .power_on  (power_on),
        .wake_done (wake_done),
        .op_state  (op_state),
        .row_ptr   (row_ptr),
        .eom_flag  (eom_flag),
        .ovf_flag  (ovf_flag)
    );

    vrscp_host_model vrscp_host_model_inst (
        .ss_n     (ss_n),
        .sclk     (sclk),
        .mosi     (mosi),
        .miso_out (miso_out),
        .miso_oe  (miso_oe)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic state_is(input vrscp_op_type op, input logic [9:0] row, input logic pwr);
        check({14'h0000, op_state}, {14'h0000, op});
        check({6'h00, row_ptr}, {6'h00, row});
        check({15'h0000, power_on}, {15'h0000, pwr});
    endtask

    // Effect lands a few cycles after select rises; 8 cycles covers it
    task automatic frame(input logic [15:0] cmd, input int nbits);
        @(posedge core_clk);
        #1;
        vrscp_host_model_inst.send_frame(cmd, nbits, stat);
        repeat (8) @(posedge core_clk);
        #1;
    endtask

    task automatic evt(input logic is_eom);
        @(posedge core_clk);
        #1;
        if (is_eom) eom_mark = 1'b1;
        else row_end = 1'b1;
        @(posedge core_clk);
        #1;
        eom_mark = 1'b0;
        row_end = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        #300000;
        bad_count++;
        close_out();
    end

    initial begin
        bad_count = 0;
        compares = 0;
        rst = 1'b1;
        row_end = 1'b0;
        eom_mark = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
        #1;
        state_is(OP_IDLE, 10'h000, 1'b0);
        check({11'h000, intr_n, miso_oe, eom_flag, ovf_flag, wake_done}, 16'h0010);
        for (int i = 0; i < 16; i++) begin
            frame(rows[i].cmd, 16);
            state_is(rows[i].op, rows[i].row, rows[i].pwr);
        end
        check({15'h0000, wake_done}, 16'h0000);
        for (int i = 0; i < 40 && wake_done !== 1'b1; i++) @(posedge core_clk);
        #1;
        check({15'h0000, wake_done}, 16'h0001);
        // End of message during playback, then status read
        frame(16'he007, 16);
        evt(1'b1);
        check({intr_n, eom_flag, 12'h000, op_state}, {2'b01, 12'h000, OP_IDLE});
        frame(16'h3000, 16);
        check({4'h0, stat[11:0]}, 16'h001e);
        check({14'h0000, intr_n, eom_flag}, 16'h0002);
        // Cue refused while playing; row repeats without skip bit
        frame(16'he100, 16);
        frame(16'he820, 16);
        state_is(OP_PLAY, 10'h100, 1'b1);
        evt(1'b0);
        state_is(OP_PLAY, 10'h100, 1'b1);
        frame(16'h3000, 16);
        frame(16'hf000, 16);
        evt(1'b0);
        state_is(OP_PLAY, 10'h101, 1'b1);
        frame(16'h3000, 16);
        // Cue from the last row overflows the array
        frame(16'hea57, 16);
        evt(1'b0);
        check({intr_n, ovf_flag, 12'h000, op_state}, {2'b01, 12'h000, OP_IDLE});
        frame(16'h3000, 16);
        check({4'h0, stat[11:0]}, 16'h095d);
        // Short frame must be ignored
        frame(16'he005, 15);
        state_is(OP_IDLE, 10'h257, 1'b1);
        check({15'h0000, miso_oe}, 16'h0000);
        // Recording ignores markers and stops only at the array end
        frame(16'hb000, 16);
        evt(1'b1);
        state_is(OP_REC, 10'h257, 1'b1);
        evt(1'b0);
        check({intr_n, ovf_flag, 12'h000, op_state}, {2'b01, 12'h000, OP_IDLE});
        close_out();
    end
endmodule
`default_nettype wire
